// ==== rtl/menu_alarm_indicator_control.sv ====
// Magnet menu, output simulation, restore and indicator control top
//
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module menu_alarm_indicator_control #(
   parameter int TICK_CYC_P = menu_pkg::TICK_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic first_magnet_switch_i,
   input wire logic second_magnet_switch_i,
   input wire logic [7:0] conc_i,
   input wire logic fault_i,
   input wire logic heater_done_i,
   input wire logic span_cal_ok_i,
   output logic first_alarm_lamp_o,
   output logic second_alarm_lamp_o,
   output logic fault_lamp_o,
   output logic [15:0] loop_ua_o,
   output logic sim_active_o,
   output logic in_menu_o,
   output logic [2:0] menu_item_o,
   output logic [2:0] scroll_count_o,
   output logic answer_o,
   output logic [7:0] edit_level_o,
   output logic restore_o,
   output logic sensor_ok_o
);
   import menu_pkg::*;
   localparam int TW = $clog2(TICK_CYC_P + 1);

   function automatic logic [2:0] item_prev(input logic [2:0] i);
      item_prev = (i == ITEM_SIM) ? ITEM_FLT : i - 3'h1;
   endfunction
   function automatic logic [2:0] item_next(input logic [2:0] i);
      item_next = (i == ITEM_FLT) ? ITEM_SIM : i + 3'h1;
   endfunction
   function automatic logic alarm_hit(input logic [7:0] c,
      input logic [7:0] lvl, input logic asc);
      alarm_hit = asc ? (c > lvl) : (c < lvl);
   endfunction

   state_t state, next_state;
   logic [2:0] item, next_item;
   logic [TW-1:0] tick_cnt;
   logic [1:0] raw, held, swipe, moment, hold3, entry, hold10;
   logic [13:0] idle_ms, step_ms;
   logic [6:0] pct;
   logic down;
   logic [23:0] cfg, next_cfg;
   logic [7:0] range, span, edit_level, next_level;
   logic edit_asc, edit_lat, next_asc, next_lat;
   logic do_restore, commit_alarm, commit_fault;
   logic heater_valid, span_valid;
   logic [2:0] cond, latch, lamp;

   wire tick = (tick_cnt == TW'(TICK_CYC_P - 1));
   wire step = tick && (step_ms == STEP_MS - 14'h0001);
   wire active = (|held) || (|swipe) || (|moment);
   wire idle_out = tick && (idle_ms >= IDLE_MS - 14'h0001);
   wire ch2 = (item == ITEM_ALM2);
   wire is_alarm = (item == ITEM_ALM1) || ch2;
   wire bus_req = wb_cyc_i && wb_stb_i;
   wire bus_wr = bus_req && wb_we_i && wb_ack_o;
   wire wr_alarm = bus_wr && (wb_adr_i == ADR_ALARM);
   wire wr_span = bus_wr && (wb_adr_i == ADR_SPAN);
   wire [7:0] lvl1 = cfg[CFG_L1 +: 8];
   wire [7:0] lvl2 = cfg[CFG_L2 +: 8];
   wire [31:0] status_word = {11'h000, span_valid, heater_valid,
      sensor_ok_o, lamp, scroll_count_o, item, state};
   wire [31:0] read_word =
      (wb_adr_i == ADR_STATUS) ? status_word :
      (wb_adr_i == ADR_ALARM) ? {8'h00, cfg} :
      (wb_adr_i == ADR_SPAN) ? {16'h0000, span, range} :
      (wb_adr_i == ADR_LOOP) ? {9'h000, pct, loop_ua_o} : 32'h00000000;

   assign raw = {second_magnet_switch_i, first_magnet_switch_i};
   generate
      for (genvar g = 0; g < 2; g++)
      begin : g_sw
         magnet_switch u_sw (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .tick_i(tick),
            .raw_i(raw[g]),
            .held_o(held[g]),
            .swipe_o(swipe[g]),
            .moment_o(moment[g]),
            .hold3_o(hold3[g]),
            .entry_o(entry[g]),
            .long_o(hold10[g])
         );
      end
   endgenerate

   // Alarm compare, strict so equality never fires
   assign cond[0] = alarm_hit(conc_i, lvl1, cfg[CFG_ASC1]);
   assign cond[1] = alarm_hit(conc_i, lvl2, cfg[CFG_ASC2]);
   assign cond[2] = fault_i;
   assign latch = {cfg[CFG_FLAT], cfg[CFG_LAT2], cfg[CFG_LAT1]};
   // Two alarm lamps and the fault lamp
   generate
      for (genvar k = 0; k < 3; k++)
      begin : g_lamp
         alarm_lamp u_lamp (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .cond_i(cond[k]),
            .latch_i(latch[k]),
            .clear_i(|swipe),
            .on_o(lamp[k])
         );
      end
   endgenerate
   assign first_alarm_lamp_o = lamp[0];
   assign second_alarm_lamp_o = lamp[1];
   assign fault_lamp_o = lamp[2];

   always_comb
   begin
      next_state = state;
      next_item = item;
      next_level = edit_level;
      next_asc = edit_asc;
      next_lat = edit_lat;
      do_restore = 1'b0;
      commit_alarm = 1'b0;
      commit_fault = 1'b0;
      case (state)
         ST_NORMAL:
            if (|moment)
            begin
               next_state = ST_MENU;
               next_item = ITEM_SIM;
            end
         ST_MENU:
            if (moment[0])
               next_item = item_prev(item);
            else if (moment[1])
               next_item = item_next(item);
            else if (idle_out)
               next_state = ST_NORMAL;
            else if ((|hold10) && item == ITEM_SIM)
               next_state = ST_SIM;
            else if (hold10[0] && item == ITEM_RESTORE)
               do_restore = 1'b1;
            else if ((|entry) && is_alarm)
            begin
               next_state = ST_LEVEL;
               next_level = ch2 ? lvl2 : lvl1;
               next_asc = ch2 ? cfg[CFG_ASC2] : cfg[CFG_ASC1];
               next_lat = ch2 ? cfg[CFG_LAT2] : cfg[CFG_LAT1];
            end
            else if ((|entry) && item == ITEM_FLT)
            begin
               next_state = ST_FLATCH;
               next_lat = cfg[CFG_FLAT];
            end
         ST_SIM:
            if (hold3[0])
            begin
               next_state = ST_MENU;
               next_item = item_prev(item);
            end
            else if (hold3[1])
            begin
               next_state = ST_MENU;
               next_item = item_next(item);
            end
         ST_LEVEL:
            if (|hold3)
               next_state = ST_DIR;
            else if (swipe[0] && edit_level < range)
               next_level = edit_level + 8'h01;
            else if (swipe[1] && edit_level != 8'h00)
               next_level = edit_level - 8'h01;
         ST_DIR:
            if (|hold3)
               next_state = ST_LATCH;
            else if (|swipe)
               next_asc = !edit_asc;
         ST_LATCH:
            if (|hold3)
               next_state = ST_ASAVE;
            else if (|swipe)
               next_lat = !edit_lat;
         ST_ASAVE:
            if (|hold3)
            begin
               next_state = ST_MENU;
               commit_alarm = 1'b1;
            end
         ST_FLATCH:
            if (|hold3)
               next_state = ST_FSAVE;
            else if (|swipe)
               next_lat = !edit_lat;
         ST_FSAVE:
            if (|hold3)
            begin
               next_state = ST_MENU;
               commit_fault = 1'b1;
            end
         default:
            next_state = ST_NORMAL;
      endcase
   end

   always_comb
   begin
      next_cfg = cfg;
      if (wr_alarm)
         for (int b = 0; b < 3; b++)
            if (wb_sel_i[b])
               next_cfg[b*8 +: 8] = wb_dat_i[b*8 +: 8];
      if (commit_alarm && ch2)
      begin
         next_cfg[CFG_L2 +: 8] = edit_level;
         next_cfg[CFG_ASC2] = edit_asc;
         next_cfg[CFG_LAT2] = edit_lat;
      end
      else if (commit_alarm)
      begin
         next_cfg[CFG_L1 +: 8] = edit_level;
         next_cfg[CFG_ASC1] = edit_asc;
         next_cfg[CFG_LAT1] = edit_lat;
      end
      if (commit_fault)
         next_cfg[CFG_FLAT] = edit_lat;
      if (do_restore)
         next_cfg = CFG_DEF;
      next_cfg = next_cfg & CFG_MASK;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i || tick)
         tick_cnt <= '0;
      else
         tick_cnt <= tick_cnt + TW'(1);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state <= ST_NORMAL;
         item <= ITEM_SIM;
         edit_level <= 8'h00;
         edit_asc <= 1'b0;
         edit_lat <= 1'b0;
         cfg <= CFG_DEF;
         restore_o <= 1'b0;
      end
      else
      begin
         state <= next_state;
         item <= next_item;
         edit_level <= next_level;
         edit_asc <= next_asc;
         edit_lat <= next_lat;
         cfg <= next_cfg;
         restore_o <= do_restore;
      end
   end

   // Menu idle timer, runs only on a menu item, cleared by switch activity
   always_ff @(posedge clk_i)
   begin
      if (rst_i || state != ST_MENU || active)
         idle_ms <= 14'h0000;
      else if (tick && idle_ms != MS_MAX)
         idle_ms <= idle_ms + 14'h0001;
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         scroll_count_o <= 3'h0;
      else
         scroll_count_o <= 3'(idle_ms / SCROLL_MS);
   end

   // Simulation ramp, no timeout applies in this state
   always_ff @(posedge clk_i)
   begin
      if (rst_i || state != ST_SIM || step)
         step_ms <= 14'h0000;
      else if (tick)
         step_ms <= step_ms + 14'h0001;
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i || state != ST_SIM)
      begin
         pct <= 7'h00;
         down <= 1'b0;
      end
      else if (step && !down && pct == PCT_MAX)
      begin
         down <= 1'b1;
         pct <= pct - 7'h01;
      end
      else if (step && down && pct == 7'h00)
      begin
         down <= 1'b0;
         pct <= 7'h01;
      end
      else if (step)
         pct <= down ? pct - 7'h01 : pct + 7'h01;
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         loop_ua_o <= LOOP_MIN_UA;
      else
         loop_ua_o <= LOOP_MIN_UA + 16'(pct) * LOOP_STEP_UA;
   end

   // Range, span and calibration validity
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         range <= RANGE_DEF;
         span <= SPAN_DEF;
         heater_valid <= 1'b0;
         span_valid <= 1'b0;
      end
      else
      begin
         if (do_restore)
         begin
            range <= RANGE_DEF;
            span <= SPAN_DEF;
         end
         else if (wr_span)
         begin
            if (wb_sel_i[0])
               range <= wb_dat_i[7:0];
            if (wb_sel_i[1])
               span <= wb_dat_i[15:8];
         end
         heater_valid <= heater_done_i || (heater_valid && !do_restore);
         span_valid <= (span_cal_ok_i && heater_valid) ||
            (span_valid && !do_restore);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         wb_ack_o <= bus_req && !wb_ack_o;
         if (bus_req && !wb_ack_o)
            wb_dat_o <= read_word;
      end
   end

   assign sensor_ok_o = heater_valid && span_valid;
   assign sim_active_o = (state == ST_SIM);
   assign in_menu_o = (state != ST_NORMAL);
   assign menu_item_o = item;
   assign answer_o = (state == ST_DIR) ? edit_asc : edit_lat;
   assign edit_level_o = edit_level;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   property p_sim_enter;
      state == ST_SIM && $past(state) != ST_SIM |->
         $past(item == ITEM_SIM && (|hold10) && state == ST_MENU);
   endproperty
   a_sim_enter: assert property (p_sim_enter)
      else $error("simulation entered without long hold");
   property p_loop;
      state == ST_SIM |=> loop_ua_o ==
         LOOP_MIN_UA + 16'($past(pct)) * LOOP_STEP_UA && pct <= PCT_MAX;
   endproperty
   a_loop: assert property (p_loop)
      else $error("loop value does not match ramp step");
   property p_no_timeout;
      state == ST_SIM && !(|hold3) |=> state == ST_SIM;
   endproperty
   a_no_timeout: assert property (p_no_timeout)
      else $error("simulation left without stop hold");
   property p_sim_stop;
      state == ST_SIM && hold3[1] && !hold3[0] |=>
         state == ST_MENU && item == item_next($past(item));
   endproperty
   a_sim_stop: assert property (p_sim_stop)
      else $error("simulation stop went to wrong item");
   property p_idle;
      state == ST_MENU && idle_out && !(|moment) |=> state == ST_NORMAL;
   endproperty
   a_idle: assert property (p_idle)
      else $error("menu did not time out");
   property p_restore;
      restore_o |-> $past(hold10[0] && item == ITEM_RESTORE) &&
         range == RANGE_DEF && span == SPAN_DEF && item == ITEM_RESTORE;
   endproperty
   a_restore: assert property (p_restore)
      else $error("restore cause or defaults wrong");
   property p_span_after_heater;
      $rose(span_valid) |-> $past(heater_valid);
   endproperty
   a_span_after_heater: assert property (p_span_after_heater)
      else $error("span valid without heater");
   property p_equal;
      conc_i == lvl1 |-> !cond[0];
   endproperty
   a_equal: assert property (p_equal)
      else $error("alarm active at threshold");
   property p_asc;
      cfg[CFG_ASC1] && conc_i > lvl1 ##1 cfg[CFG_ASC1] && conc_i > lvl1
         |-> lamp[0];
   endproperty
   a_asc: assert property (p_asc)
      else $error("ascending alarm not lit");
   c_sim: cover property (state == ST_SIM ##1 step);
   c_restore: cover property (restore_o);
   c_alarm_save: cover property (commit_alarm);
   c_fault_save: cover property (commit_fault);
endmodule

// ==== rtl/menu_pkg.sv ====
// Shared constants and types for the magnet menu and indicator control
package menu_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int TICK_MS = 1;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam logic [13:0] DEBOUNCE_MS = 14'h0014;
   localparam logic [13:0] SWIPE_MAX_MS = 14'h01f4;
   localparam logic [13:0] HOLD_MS = 14'h0bb8;
   localparam logic [13:0] PROMPT_MS = 14'h03e8;
   localparam logic [13:0] ENTRY_MS = PROMPT_MS + 14'h0bb8;
   localparam logic [13:0] LONG_MS = PROMPT_MS + 14'h2710;
   localparam logic [13:0] MS_MAX = 14'h3fff;
   localparam logic [13:0] STEP_MS = 14'h03e8;
   localparam logic [13:0] IDLE_MS = 14'h3a98;
   localparam logic [13:0] SCROLL_MS = 14'h0ea6;
   localparam logic [15:0] LOOP_MIN_UA = 16'h0fa0;
   localparam logic [15:0] LOOP_STEP_UA = 16'h00a0;
   localparam logic [6:0] PCT_MAX = 7'h64;
   localparam logic [7:0] RANGE_DEF = 8'h64;
   localparam logic [7:0] SPAN_DEF = 8'h19;
   localparam logic [7:0] ALM1_DEF = 8'h0a;
   localparam logic [7:0] ALM2_DEF = 8'h14;
   localparam logic [3:0] ADR_STATUS = 4'h0;
   localparam logic [3:0] ADR_ALARM = 4'h4;
   localparam logic [3:0] ADR_SPAN = 4'h8;
   localparam logic [3:0] ADR_LOOP = 4'hc;
   localparam int CFG_L1 = 0;
   localparam int CFG_L2 = 8;
   localparam int CFG_ASC1 = 16;
   localparam int CFG_ASC2 = 17;
   localparam int CFG_LAT1 = 18;
   localparam int CFG_LAT2 = 19;
   localparam int CFG_FLAT = 20;
   localparam logic [23:0] CFG_MASK = 24'h1fffff;
   localparam logic [23:0] CFG_DEF = {8'h03, ALM2_DEF, ALM1_DEF};
   localparam logic [2:0] ITEM_SIM = 3'h0;
   localparam logic [2:0] ITEM_RESTORE = 3'h1;
   localparam logic [2:0] ITEM_ALM1 = 3'h2;
   localparam logic [2:0] ITEM_ALM2 = 3'h3;
   localparam logic [2:0] ITEM_FLT = 3'h4;
   typedef enum logic [8:0] {
      ST_NORMAL = 9'h001,
      ST_MENU = 9'h002,
      ST_SIM = 9'h004,
      ST_LEVEL = 9'h008,
      ST_DIR = 9'h010,
      ST_LATCH = 9'h020,
      ST_ASAVE = 9'h040,
      ST_FLATCH = 9'h080,
      ST_FSAVE = 9'h100
   } state_t;
endpackage

// ==== rtl/magnet_switch.sv ====
// Magnet switch synchroniser, debouncer and hold classifier
`timescale 1ns/1ps
module magnet_switch (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tick_i,
   input wire logic raw_i,
   output logic held_o,
   output logic swipe_o,
   output logic moment_o,
   output logic hold3_o,
   output logic entry_o,
   output logic long_o
);
   import menu_pkg::*;
   logic s1, s2, held;
   logic [13:0] db_cnt, ms;
   wire changing = (s2 != held);
   wire db_done = changing && tick_i && (db_cnt == DEBOUNCE_MS - 14'h0001);
   wire release_ev = db_done && held;
   wire at_ms = held && tick_i;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s1 <= 1'b0;
         s2 <= 1'b0;
      end
      else
      begin
         s1 <= raw_i;
         s2 <= s1;
      end
   end
   // Stable for the debounce time before the level is accepted
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !changing || db_done)
         db_cnt <= 14'h0000;
      else if (tick_i)
         db_cnt <= db_cnt + 14'h0001;
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         held <= 1'b0;
         ms <= 14'h0000;
         swipe_o <= 1'b0;
         moment_o <= 1'b0;
         hold3_o <= 1'b0;
         entry_o <= 1'b0;
         long_o <= 1'b0;
      end
      else
      begin
         if (db_done)
            held <= s2;
         if (!held)
            ms <= 14'h0000;
         else if (tick_i && ms != MS_MAX)
            ms <= ms + 14'h0001;
         // Classify by hold duration
         swipe_o <= release_ev && (ms < SWIPE_MAX_MS);
         moment_o <= release_ev && (ms >= SWIPE_MAX_MS) && (ms < HOLD_MS);
         hold3_o <= at_ms && (ms == HOLD_MS - 14'h0001);
         entry_o <= at_ms && (ms == ENTRY_MS - 14'h0001);
         long_o <= at_ms && (ms == LONG_MS - 14'h0001);
      end
   end
   assign held_o = held;
   property p_one_class;
      @(posedge clk_i) disable iff (rst_i)
      !(swipe_o && moment_o) && !(hold3_o && entry_o);
   endproperty
   a_one_class: assert property (p_one_class)
      else $error("switch classes overlap");
endmodule

// ==== rtl/alarm_lamp.sv ====
// Indicator lamp with optional latching and swipe clear
`timescale 1ns/1ps
module alarm_lamp (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cond_i,
   input wire logic latch_i,
   input wire logic clear_i,
   output logic on_o
);
   // Condition wins over a clear in the same cycle
   wire next_on = cond_i || (latch_i && on_o && !clear_i);
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         on_o <= 1'b0;
      else
         on_o <= next_on;
   end
   property p_follow;
      @(posedge clk_i) disable iff (rst_i)
      !latch_i |=> on_o == $past(cond_i);
   endproperty
   a_follow: assert property (p_follow)
      else $error("non-latching lamp does not follow condition");
   property p_keep;
      @(posedge clk_i) disable iff (rst_i)
      latch_i && on_o && !clear_i |=> on_o;
   endproperty
   a_keep: assert property (p_keep)
      else $error("latched lamp dropped without swipe");
endmodule

// ==== test/magnet_operator.sv ====
// Operator model holding a magnet over either switch
`timescale 1ns/1ps
module magnet_operator #(
   parameter int TICK_P = 1
) (
   input wire logic clk_i,
   output logic sw1_o,
   output logic sw2_o
);
   initial
   begin
      sw1_o = 1'b0;
      sw2_o = 1'b0;
   end
   // Hold one switch for ms milliseconds, contacts bounce at first
   task automatic hold(input bit second, input int ms);
      int i;
      for (i = 0; i < ms * TICK_P + 8; i++)
      begin
         @(posedge clk_i);
         if (second)
            sw2_o <= (i < 8) ? i[0] : 1'b1;
         else
            sw1_o <= (i < 8) ? i[0] : 1'b1;
      end
      @(posedge clk_i);
      sw1_o <= 1'b0;
      sw2_o <= 1'b0;
   endtask
endmodule

// ==== test/tb_menu_alarm_indicator_control.sv ====
// Self-checking bench for the magnet menu and indicator control
`timescale 1ns/1ps
module tb_menu_alarm_indicator_control;
   import menu_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [3:0] wb_adr = 4'h0;
   logic [31:0] wb_wdat = 32'h0;
   logic [31:0] wb_rdat;
   logic wb_ack;
   logic sw1;
   logic sw2;
   logic fault = 1'b0;
   logic heater = 1'b0;
   logic span_ok = 1'b0;
   logic [7:0] conc = 8'h00;
   logic lamp1;
   logic lamp2;
   logic flamp;
   logic sim;
   logic menu;
   logic sens_ok;
   logic answer;
   logic restore;
   logic [2:0] scroll;
   int restores = 0;
   logic [15:0] loop_ua;
   logic [2:0] item;
   logic [31:0] rd;
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   magnet_operator #(.TICK_P(1)) op (.clk_i(clk_i), .sw1_o(sw1), .sw2_o(sw2));
   menu_alarm_indicator_control #(.TICK_CYC_P(1)) uut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf),
      .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
      .first_magnet_switch_i(sw1), .second_magnet_switch_i(sw2),
      .conc_i(conc), .fault_i(fault), .heater_done_i(heater),
      .span_cal_ok_i(span_ok), .first_alarm_lamp_o(lamp1),
      .second_alarm_lamp_o(lamp2), .fault_lamp_o(flamp),
      .loop_ua_o(loop_ua), .sim_active_o(sim), .in_menu_o(menu),
      .menu_item_o(item), .scroll_count_o(scroll), .answer_o(answer),
      .edit_level_o(), .restore_o(restore), .sensor_ok_o(sens_ok));
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 95000)
      begin
         num_errors++;
         wrap_up();
      end
   end
   // Counts one-cycle restore pulses
   always @(posedge clk_i)
   begin
      if (restore === 1'b1)
         restores++;
   end
   task automatic check(input string name, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Classic single Wishbone cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= a;
      wb_wdat <= d;
      @(posedge clk_i);
      while (wb_ack !== 1'b1)
         @(posedge clk_i);
      rd = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic gas(input logic [7:0] c, input logic f);
      @(posedge clk_i);
      conc <= c;
      fault <= f;
      repeat (3) @(posedge clk_i);
   endtask
   task automatic swipe();
      op.hold(1'b0, 100);
      repeat (60) @(posedge clk_i);
   endtask
   // Hold, then let the debouncer see the release before going on
   task automatic press(input bit second, input int ms);
      op.hold(second, ms);
      repeat (60) @(posedge clk_i);
   endtask
   task automatic t_regs();
      wb(1'b0, ADR_ALARM, 32'h0);
      check("alarm_rst", rd, {8'h00, CFG_DEF});
      wb(1'b1, 4'h2, 32'hffff_ffff);
      check("unmapped", rd, 32'h0);
      wb(1'b0, 4'h2, 32'h0);
      check("unmapped_rd", rd, 32'h0);
      wb(1'b1, ADR_ALARM, 32'h0009_3030);
      wb(1'b0, ADR_ALARM, 32'h0);
      check("alarm_wr", rd, 32'h0009_3030);
   endtask
   task automatic t_alarm();
      gas(8'h30, 1'b0);
      swipe();
      check("equal", {lamp1, lamp2}, 2'b00);
      gas(8'h31, 1'b0);
      check("above", {lamp1, lamp2}, 2'b10);
      gas(8'h2f, 1'b0);
      check("below", {lamp1, lamp2}, 2'b01);
      gas(8'h30, 1'b0);
      check("latched", {lamp1, lamp2}, 2'b01);
      swipe();
      check("swiped", lamp2, 1'b0);
   endtask
   task automatic t_fault();
      gas(8'h30, 1'b1);
      check("flt_on", flamp, 1'b1);
      gas(8'h30, 1'b0);
      check("flt_nl", flamp, 1'b0);
      wb(1'b1, ADR_ALARM, 32'h0019_3030);
      gas(8'h30, 1'b1);
      gas(8'h30, 1'b0);
      check("flt_lat", flamp, 1'b1);
      swipe();
      check("flt_clr", flamp, 1'b0);
   endtask
   task automatic t_restore();
      wb(1'b1, ADR_SPAN, 32'h0000_0a32);
      press(1'b1, 1000);
      check("menu_in", {menu, item}, 4'h8);
      press(1'b1, 1000);
      check("next", item, ITEM_RESTORE);
      press(1'b0, 5000);
      wb(1'b0, ADR_SPAN, 32'h0);
      check("short", rd, 32'h0000_0a32);
      check("no_rst", restores, 0);
      press(1'b0, 11100);
      check("rst_once", restores, 1);
      wb(1'b0, ADR_SPAN, 32'h0);
      check("span_def", rd, 32'h0000_1964);
      wb(1'b0, ADR_ALARM, 32'h0);
      check("cfg_def", rd, {8'h00, CFG_DEF});
      check("rst_item", item, ITEM_RESTORE);
      gas(8'h30, 1'b0);
      span_ok <= 1'b1;
      repeat (3) @(posedge clk_i);
      check("no_heat", sens_ok, 1'b0);
      span_ok <= 1'b0;
      heater <= 1'b1;
      @(posedge clk_i);
      span_ok <= 1'b1;
      repeat (3) @(posedge clk_i);
      check("oper", sens_ok, 1'b1);
      heater <= 1'b0;
      span_ok <= 1'b0;
   endtask
   task automatic t_sim();
      press(1'b0, 1000);
      check("prev", item, ITEM_SIM);
      op.hold(1'b1, 11100);
      check("sim_on", sim, 1'b1);
      repeat (1400) @(posedge clk_i);
      check("step1", loop_ua, 16'h1040);
      repeat (1000) @(posedge clk_i);
      check("step2", loop_ua, 16'h10e0);
      repeat (16000) @(posedge clk_i);
      check("no_tmo", sim, 1'b1);
      op.hold(1'b1, 3100);
      check("stop", {sim, menu, item}, 5'h09);
      repeat (8000) @(posedge clk_i);
      check("scroll", scroll, 3'h2);
      repeat (7500) @(posedge clk_i);
      check("idle", menu, 1'b0);
   endtask
   task automatic t_fset();
      press(1'b1, 1000);
      press(1'b0, 1000);
      check("flt_item", item, ITEM_FLT);
      press(1'b1, 4100);
      check("flt_ans", answer, 1'b0);
      swipe();
      check("flt_tgl", answer, 1'b1);
      press(1'b1, 3100);
      press(1'b1, 3100);
      wb(1'b0, ADR_ALARM, 32'h0);
      check("flt_save", rd, {8'h00, CFG_DEF} | 32'h0010_0000);
      gas(8'h30, 1'b1);
      gas(8'h30, 1'b0);
      check("flt_hold", flamp, 1'b1);
   endtask
   task automatic wrap_up();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      check("loop_rst", loop_ua, LOOP_MIN_UA);
      t_regs();
      t_alarm();
      t_fault();
      t_restore();
      t_sim();
      t_fset();
      wrap_up();
   end
endmodule
